// ===== dv/csioc_ref_source.sv
// model: input reference source that can fall silent
`default_nettype none
module csioc_ref_source #(
  parameter real HALF = 23.7
) (
  input wire logic running,
  output logic refClock
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // reference edges
  // ****************
  initial refClock = 1'b0;
  // a silent source holds its last level, as a stopped oscillator does
  always begin
    #HALF;
    if (running) refClock = ~refClock;
  end
endmodule // csioc_ref_source
`default_nettype wire

// ===== dv/csioc_top_monitor.sv
// checker: concurrent properties on the clock synth control ports
`default_nettype none
module csioc_top_monitor #(
  parameter int DETECT_CYCLES = 500
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic refClock,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [csioc_pkg::NUM_OUTS-1:0] device_clock_output,
  input wire logic [csioc_pkg::NUM_BANKS-1:0] bankPowered,
  input wire logic holdoverActive,
  input wire logic pllTracking,
  input wire logic tuneMidSupply,
  input wire logic signal_loss_status
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // quiet counter
  // ****************
  logic [15:0] quietCount;
  logic [15:0] next_quietCount;
  logic refPrev;
  // saturates so a long silence never wraps back into the quiet window
  always_comb begin
    next_quietCount = (refClock != refPrev) ? 16'h0000 : quietCount + 16'h0001;
    if (quietCount == 16'hffff) next_quietCount = quietCount;
  end
  always_ff @(posedge clk_sys) begin
    refPrev <= refClock;
    quietCount <= resetn ? next_quietCount : 16'h0000;
  end
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence refEdge;
    refClock != refPrev;
  endsequence
  sequence lossClears;
    ##[1:8] !signal_loss_status;
  endsequence
  property sleepLow(logic p, logic [1:0] o);
    !p [*2] |-> o == 2'b00;
  endproperty
  a_loss_after_quiet: assert property (
    quietCount >= DETECT_CYCLES + 8 |-> signal_loss_status) else $error("loss flag missing after silence");
  a_no_early_loss: assert property (
    quietCount > 16'h0008 && quietCount < DETECT_CYCLES - 2 |-> !signal_loss_status) else $error("early loss flag");
  a_loss_clears: assert property (refEdge |-> lossClears) else $error("loss flag stuck with activity");
  a_hold_on_loss: assert property (
    $rose(signal_loss_status) |-> holdoverActive && tuneMidSupply) else $error("no holdover on loss");
  a_track_stops: assert property (
    pllTracking == !holdoverActive && tuneMidSupply == holdoverActive) else $error("tracking state wrong");
  a_sleep_bank_a: assert property (sleepLow(bankPowered[0], device_clock_output[1:0])) else $error("bank a runs");
  a_sleep_bank_b: assert property (sleepLow(bankPowered[1], device_clock_output[3:2])) else $error("bank b runs");
  a_sleep_bank_c: assert property (
    sleepLow(bankPowered[2], {1'b0, device_clock_output[4]})) else $error("bank c runs");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
  a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write response repeats");
endmodule // csioc_top_monitor
bind csioc_top csioc_top_monitor #(.DETECT_CYCLES(DETECT_CYCLES)) i_csioc_top_monitor (.clk_sys, .resetn, .refClock,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .device_clock_output, .bankPowered,
  .holdoverActive, .pllTracking, .tuneMidSupply, .signal_loss_status);
`default_nettype wire

// ===== dv/testbench.sv
// testbench: registers, loss monitor, holdover, dividers and outputs of the clock synth control
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // signals
  // ****************
  localparam int DET = 20;
  logic clk_sys = 1'b0, resetn = 1'b0, refRun = 1'b1, refClock;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h0000f53d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [4:0] device_clock_output, format_select;
  logic [9:0] outputAmplitude;
  logic [2:0] bankPowered;
  logic [5:0] pump_current_code;
  logic holdoverActive, pllTracking, tuneMidSupply, signal_loss_status, irq;
  int err_count = 0, tests_run = 0, cyc = 0;
  int ratioTab[18] = '{1, 2, 3, 4, 5, 6, 8, 10, 12, 16, 20, 24, 32, 40, 48, 64, 80, 96};
  csioc_top #(.DETECT_CYCLES(DET)) i_csioc_top (.clk_sys, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .refClock, .device_clock_output, .format_select, .outputAmplitude, .bankPowered, .pump_current_code,
    .holdoverActive, .pllTracking, .tuneMidSupply, .signal_loss_status, .irq);
  csioc_ref_source i_csioc_ref_source (.running(refRun), .refClock);
  always #10 clk_sys = ~clk_sys;
  // hang guard: the whole run needs well under this many cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      finish_test();
    end
  end
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
    // an edge passes before the next transfer raises ready again
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge clk_sys);
  endtask
  task automatic rdck(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d, exp);
  endtask
  // a full period is timed from one rise to the next; ratio one never falls
  task automatic period(input int o, output int per, output int hi);
    int k;
    per = 1;
    hi = 1;
    for (k = 0; k < 200 && device_clock_output[o]; k++) @(posedge clk_sys);
    if (k == 200) return;
    while (!device_clock_output[o]) @(posedge clk_sys);
    per = 0;
    hi = 0;
    while (device_clock_output[o]) begin
      hi++;
      per++;
      @(posedge clk_sys);
    end
    while (!device_clock_output[o]) begin
      per++;
      @(posedge clk_sys);
    end
  endtask
  task automatic note(input string s);
    $display("test %s done, %0d checks, %0d mismatches", s, tests_run, err_count);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  initial begin
    logic [31:0] d;
    int per, hi, o, c;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    check({bankPowered, device_clock_output, irq}, 9'h1c0);
    rdck(8'h00, 32'h0);
    rdck(8'h04, 32'h0);
    rdck(8'h0c, 32'h0);
    rdck(8'h10, 32'h0);
    rdck(8'h20, 32'h0);
    rd(8'hfc, d);
    check(resp, 2'h3);
    check(d, 32'h0);
    wr(8'hfc, 32'hffffffff);
    check(resp, 2'h3);
    note("reset");
    for (c = 0; c < 8; c++) begin
      d = c == 0 ? 32'h0 : c == 1 ? 32'h3f : rnd() & 32'h3f;
      wr(8'h00, d << 8);
      check(pump_current_code, d);
      rdck(8'h00, d << 8);
    end
    wr(8'h00, 32'h1);
    check({holdoverActive, pllTracking, tuneMidSupply}, 3'h5);
    rdck(8'h04, 32'h2);
    wr(8'h00, 32'h0);
    check({holdoverActive, pllTracking, tuneMidSupply}, 3'h2);
    note("pump and hold");
    wr(8'h0c, 32'h3);
    refRun <= 1'b0;
    repeat (DET + 12) @(posedge clk_sys);
    check({signal_loss_status, holdoverActive, tuneMidSupply, irq}, 4'hf);
    rdck(8'h04, 32'h3);
    rdck(8'h08, 32'h1);
    wr(8'h08, 32'h1);
    check(irq, 1'b0);
    refRun <= 1'b1;
    repeat (12) @(posedge clk_sys);
    check({signal_loss_status, holdoverActive, irq}, 3'h1);
    rdck(8'h08, 32'h2);
    wr(8'h0c, 32'h1);
    check(irq, 1'b0);
    wr(8'h08, 32'h2);
    wr(8'h0c, 32'h3);
    check(irq, 1'b0);
    note("loss");
    for (c = 0; c < 28; c++) begin
      o = c < 8 ? 4 : rnd() % 5;
      d = c < 8 ? c : rnd() & 32'h7;
      wr(8'h20 + 8'(4 * o), d);
      check({format_select[o], outputAmplitude[2*o+:2]}, {d[0], d[2:1]});
      rdck(8'h20 + 8'(4 * o), d);
    end
    check(device_clock_output, 5'h00);
    note("outputs");
    for (o = 0; o < 5; o++) wr(8'h20 + 8'(4 * o), 32'h8);
    for (o = 0; o < 3; o++) begin
      for (c = 0; c < 19; c++) begin
        wr(8'h10 + 8'(4 * o), c);
        period(2 * o, per, hi);
        check(per, ratioTab[c < 18 ? c : 17]);
        check(hi, ratioTab[c < 18 ? c : 17] / 2 + (c == 0));
      end
      wr(8'h10 + 8'(4 * o), 32'h101);
      repeat (10) @(posedge clk_sys);
      check({bankPowered[o], device_clock_output[2*o]}, 2'h0);
      wr(8'h10 + 8'(4 * o), 32'h0);
    end
    wr(8'h24, 32'h0);
    check(device_clock_output, 5'h1d);
    note("dividers");
    finish_test();
  end
endmodule // testbench
`default_nettype wire

// ===== rtl/csioc_activity_monitor.sv
// module: input reference activity monitor with loss detection
`default_nettype none
module csioc_activity_monitor #(
  parameter int DETECT_CYCLES = csioc_pkg::DETECT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic refClock,
  output logic inputAbsent,
  output logic lossEvent,
  output logic returnEvent
);
  logic syncA, syncB, syncC;
  logic [15:0] quietCount, next_quietCount;
  logic next_inputAbsent;
  logic activity;

  // ****************************************
  // synchroniser and edge detect
  // ****************************************
  // syncA is read only by syncB; edges are seen on the settled stages
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
      syncC <= 1'b0;
    end else begin
      syncA <= refClock;
      syncB <= syncA;
      syncC <= syncB;
    end
  end
  assign activity = syncB ^ syncC;

  // ****************************************
  // quiet interval counter
  // ****************************************
  always_comb begin
    next_quietCount = quietCount;
    next_inputAbsent = inputAbsent;
    if (activity) begin
      next_quietCount = 16'h0000;
      next_inputAbsent = 1'b0;
    end else if (quietCount >= 16'(DETECT_CYCLES - 1)) begin
      next_inputAbsent = 1'b1;
    end else begin
      next_quietCount = quietCount + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      quietCount <= 16'h0000;
      inputAbsent <= 1'b0;
    end else begin
      quietCount <= next_quietCount;
      inputAbsent <= next_inputAbsent;
    end
  end

  assign lossEvent = next_inputAbsent & ~inputAbsent;
  assign returnEvent = ~next_inputAbsent & inputAbsent;
endmodule // csioc_activity_monitor
`default_nettype wire

// ===== rtl/csioc_bank_divider.sv
// module: one bank output divider with sleep control
`default_nettype none
module csioc_bank_divider #(
  parameter int RATIO_W = csioc_pkg::RATIO_W
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [RATIO_W-1:0] ratio,
  input wire logic channelSleep,
  output logic bankClock
);
  logic [RATIO_W-1:0] phase, next_phase, lastRatio;
  logic next_bankClock;

  // ****************************************
  // counter; a ratio change restarts the cycle
  // ****************************************
  always_comb begin
    next_phase = phase + 7'(1);
    if (channelSleep || ratio != lastRatio || phase >= ratio - 7'(1)) begin
      next_phase = '0;
    end
    // high for the first half; ratio one stays high since the tick is the clock itself
    next_bankClock = ~channelSleep & ((ratio == 7'(1)) | (next_phase < (ratio >> 1)));
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      phase <= '0;
      lastRatio <= 7'(1);
      bankClock <= 1'b0;
    end else begin
      phase <= next_phase;
      lastRatio <= ratio;
      bankClock <= next_bankClock;
    end
  end
endmodule // csioc_bank_divider
`default_nettype wire

// ===== rtl/csioc_pkg.sv
// package: register map, field layout, reset values and timing for the clock synth control block
`default_nettype none
package csioc_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_BANK_BASE = 8'h10;
  localparam logic [7:0] ADDR_OUT_BASE = 8'h20;
  localparam int NUM_BANKS = 3;
  localparam int NUM_OUTS = 5;
  // ****************************************
  // field positions and widths
  // ****************************************
  localparam int CTRL_HOLD_BIT = 0;
  localparam int CTRL_PUMP_LSB = 8;
  localparam int PUMP_W = 6;
  localparam int STAT_LOSS_BIT = 0;
  localparam int STAT_HOLD_BIT = 1;
  localparam int IRQ_LOSS_BIT = 0;
  localparam int IRQ_RETURN_BIT = 1;
  localparam int IRQ_W = 2;
  localparam int BANK_SEL_LSB = 0;
  localparam int BANK_SEL_W = 5;
  localparam int BANK_SLEEP_BIT = 8;
  localparam int OUT_FMT_BIT = 0;
  localparam int OUT_AMP_LSB = 1;
  localparam int OUT_GATE_BIT = 3;
  localparam int RATIO_W = 7;
  localparam int NUM_RATIOS = 18;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic CTRL_HOLD_RST = 1'b0;
  localparam logic [5:0] PUMP_RST = 6'h00;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [4:0] BANK_SEL_RST = 5'h00;
  localparam logic BANK_SLEEP_RST = 1'b0;
  localparam logic [3:0] OUT_CFG_RST = 4'h0;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int DETECT_NS = 10000;
  localparam int DETECT_CYCLES = (DETECT_NS / CLK_PERIOD_NS) < 1 ? 1 : (DETECT_NS / CLK_PERIOD_NS);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // selector code to divide ratio; codes past the list return zero (illegal)
  function automatic logic [RATIO_W-1:0] csioc_ratio(input logic [BANK_SEL_W-1:0] sel);
    case (sel)
      5'h00: csioc_ratio = 7'h01;
      5'h01: csioc_ratio = 7'h02;
      5'h02: csioc_ratio = 7'h03;
      5'h03: csioc_ratio = 7'h04;
      5'h04: csioc_ratio = 7'h05;
      5'h05: csioc_ratio = 7'h06;
      5'h06: csioc_ratio = 7'h08;
      5'h07: csioc_ratio = 7'h0a;
      5'h08: csioc_ratio = 7'h0c;
      5'h09: csioc_ratio = 7'h10;
      5'h0a: csioc_ratio = 7'h14;
      5'h0b: csioc_ratio = 7'h18;
      5'h0c: csioc_ratio = 7'h20;
      5'h0d: csioc_ratio = 7'h28;
      5'h0e: csioc_ratio = 7'h30;
      5'h0f: csioc_ratio = 7'h40;
      5'h10: csioc_ratio = 7'h50;
      5'h11: csioc_ratio = 7'h60;
      default: csioc_ratio = 7'h00;
    endcase
  endfunction
endpackage
`default_nettype wire

// ===== rtl/csioc_top.sv
// module: clock synth input monitor, holdover, divider and output control with AXI4-Lite registers
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`default_nettype none
module csioc_top #(
  parameter int DETECT_CYCLES = csioc_pkg::DETECT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic refClock,
  output logic [csioc_pkg::NUM_OUTS-1:0] device_clock_output,
  output logic [csioc_pkg::NUM_OUTS-1:0] format_select,
  output logic [2*csioc_pkg::NUM_OUTS-1:0] outputAmplitude,
  output logic [csioc_pkg::NUM_BANKS-1:0] bankPowered,
  output logic [csioc_pkg::PUMP_W-1:0] pump_current_code,
  output logic holdoverActive,
  output logic pllTracking,
  output logic tuneMidSupply,
  output logic signal_loss_status,
  output logic irq
);
  localparam int NB = csioc_pkg::NUM_BANKS;
  localparam int NO = csioc_pkg::NUM_OUTS;
  // output to bank map: two outputs on A, two on B, one on C
  localparam int OUT_BANK [NO] = '{0, 0, 1, 1, 2};

  // ****************************************
  // register state
  // ****************************************
  logic holdRequest, next_holdRequest;
  logic [5:0] pumpCode, next_pumpCode;
  logic [1:0] irqStatus, next_irqStatus;
  logic [1:0] irqMask, next_irqMask;
  logic [4:0] bankSel [NB];
  logic [4:0] next_bankSel [NB];
  logic bankSleep [NB];
  logic next_bankSleep [NB];
  logic [3:0] outCfg [NO];
  logic [3:0] next_outCfg [NO];
  logic awHeld, next_awHeld, wHeld, next_wHeld;
  logic [7:0] awAddr, next_awAddr;
  logic [31:0] wData, next_wData;
  logic [3:0] wStrb, next_wStrb;
  logic bValid, next_bValid;
  logic [1:0] bResp, next_bResp;
  logic rValid, next_rValid;
  logic [31:0] rData, next_rData;
  logic [1:0] rResp, next_rResp;
  logic inputAbsent, lossEvent, returnEvent;
  logic [NB-1:0] bankClock;
  logic doWrite;
  logic [32:0] heldWord;
  logic [31:0] wordIn;

  // merge written bytes into the current value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? data[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // current value of a register word, and whether the address is mapped
  function automatic logic [32:0] read_word(input logic [7:0] addr);
    logic [32:0] r;
    r = {1'b0, 32'h0};
    if (addr == csioc_pkg::ADDR_CTRL) begin
      r = {1'b1, 32'h0};
      r[csioc_pkg::CTRL_HOLD_BIT] = holdRequest;
      r[csioc_pkg::CTRL_PUMP_LSB +: csioc_pkg::PUMP_W] = pumpCode;
    end else if (addr == csioc_pkg::ADDR_STATUS) begin
      r = {1'b1, 32'h0};
      r[csioc_pkg::STAT_LOSS_BIT] = inputAbsent;
      r[csioc_pkg::STAT_HOLD_BIT] = holdoverActive;
    end else if (addr == csioc_pkg::ADDR_IRQ_STAT) begin
      r = {1'b1, 30'h0, irqStatus};
    end else if (addr == csioc_pkg::ADDR_IRQ_MASK) begin
      r = {1'b1, 30'h0, irqMask};
    end
    for (int b = 0; b < NB; b++) begin
      if (addr == csioc_pkg::ADDR_BANK_BASE + 8'(4 * b)) begin
        r = {1'b1, 32'h0};
        r[csioc_pkg::BANK_SEL_LSB +: csioc_pkg::BANK_SEL_W] = bankSel[b];
        r[csioc_pkg::BANK_SLEEP_BIT] = bankSleep[b];
      end
    end
    for (int o = 0; o < NO; o++) begin
      if (addr == csioc_pkg::ADDR_OUT_BASE + 8'(4 * o)) begin
        r = {1'b1, 28'h0, outCfg[o]};
      end
    end
    return r;
  endfunction

  // ****************************************
  // input monitor and bank dividers
  // ****************************************
  csioc_activity_monitor #(
    .DETECT_CYCLES(DETECT_CYCLES)
  ) u_monitor (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .refClock(refClock),
    .inputAbsent(inputAbsent),
    .lossEvent(lossEvent),
    .returnEvent(returnEvent)
  );

  for (genvar b = 0; b < NB; b++) begin : g_bank
    csioc_bank_divider #(
      .RATIO_W(csioc_pkg::RATIO_W)
    ) u_div (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .ratio(csioc_pkg::csioc_ratio(bankSel[b])),
      .channelSleep(bankSleep[b]),
      .bankClock(bankClock[b])
    );
  end

  // ****************************************
  // AXI4-Lite write and read channels
  // ****************************************
  assign s_axi_awready = ~awHeld & ~bValid;
  assign s_axi_wready = ~wHeld & ~bValid;
  assign s_axi_arready = ~rValid;
  assign doWrite = awHeld & wHeld & ~bValid;
  // a process, so register changes read inside read_word retrigger it
  always_comb begin
    heldWord = read_word(awAddr);
    wordIn = merge(heldWord[31:0], wData, wStrb);
  end

  always_comb begin
    logic [32:0] rw;
    rw = read_word(s_axi_araddr);
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld = wHeld;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bValid = bValid;
    next_bResp = bResp;
    next_rValid = rValid;
    next_rData = rData;
    next_rResp = rResp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bValid = 1'b1;
      next_bResp = heldWord[32] ? csioc_pkg::RESP_OKAY : csioc_pkg::RESP_DECERR;
    end else if (bValid && s_axi_bready) begin
      next_bValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rValid = 1'b1;
      next_rData = rw[31:0];
      next_rResp = rw[32] ? csioc_pkg::RESP_OKAY : csioc_pkg::RESP_DECERR;
    end else if (rValid && s_axi_rready) begin
      next_rValid = 1'b0;
    end
  end

  // ****************************************
  // register updates
  // ****************************************
  always_comb begin
    next_holdRequest = holdRequest;
    next_pumpCode = pumpCode;
    next_irqMask = irqMask;
    next_irqStatus = irqStatus;
    for (int b = 0; b < NB; b++) begin
      next_bankSel[b] = bankSel[b];
      next_bankSleep[b] = bankSleep[b];
    end
    for (int o = 0; o < NO; o++) begin
      next_outCfg[o] = outCfg[o];
    end
    if (doWrite) begin
      if (awAddr == csioc_pkg::ADDR_CTRL) begin
        next_holdRequest = wordIn[csioc_pkg::CTRL_HOLD_BIT];
        next_pumpCode = wordIn[csioc_pkg::CTRL_PUMP_LSB +: csioc_pkg::PUMP_W];
      end
      if (awAddr == csioc_pkg::ADDR_IRQ_MASK) begin
        next_irqMask = wordIn[1:0];
      end
      if (awAddr == csioc_pkg::ADDR_IRQ_STAT) begin
        next_irqStatus = irqStatus & ~(wData[1:0] & {2{wStrb[0]}});
      end
      for (int b = 0; b < NB; b++) begin
        if (awAddr == csioc_pkg::ADDR_BANK_BASE + 8'(4 * b)) begin
          // an unlisted ratio code is dropped and the old ratio stays
          if (csioc_pkg::csioc_ratio(wordIn[csioc_pkg::BANK_SEL_LSB +: csioc_pkg::BANK_SEL_W]) != 7'h00) begin
            next_bankSel[b] = wordIn[csioc_pkg::BANK_SEL_LSB +: csioc_pkg::BANK_SEL_W];
          end
          next_bankSleep[b] = wordIn[csioc_pkg::BANK_SLEEP_BIT];
        end
      end
      for (int o = 0; o < NO; o++) begin
        if (awAddr == csioc_pkg::ADDR_OUT_BASE + 8'(4 * o)) begin
          next_outCfg[o] = wordIn[3:0];
        end
      end
    end
    // new events win over a clear in the same cycle
    if (lossEvent) begin
      next_irqStatus[csioc_pkg::IRQ_LOSS_BIT] = 1'b1;
    end
    if (returnEvent) begin
      next_irqStatus[csioc_pkg::IRQ_RETURN_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      awHeld <= 1'b0;
      awAddr <= 8'h00;
      wHeld <= 1'b0;
      wData <= 32'h0;
      wStrb <= 4'h0;
      bValid <= 1'b0;
      bResp <= csioc_pkg::RESP_OKAY;
      rValid <= 1'b0;
      rData <= 32'h0;
      rResp <= csioc_pkg::RESP_OKAY;
      holdRequest <= csioc_pkg::CTRL_HOLD_RST;
      pumpCode <= csioc_pkg::PUMP_RST;
      irqStatus <= 2'h0;
      irqMask <= csioc_pkg::IRQ_MASK_RST;
      for (int b = 0; b < NB; b++) begin
        bankSel[b] <= csioc_pkg::BANK_SEL_RST;
        bankSleep[b] <= csioc_pkg::BANK_SLEEP_RST;
      end
      for (int o = 0; o < NO; o++) begin
        outCfg[o] <= csioc_pkg::OUT_CFG_RST;
      end
    end else begin
      awHeld <= next_awHeld;
      awAddr <= next_awAddr;
      wHeld <= next_wHeld;
      wData <= next_wData;
      wStrb <= next_wStrb;
      bValid <= next_bValid;
      bResp <= next_bResp;
      rValid <= next_rValid;
      rData <= next_rData;
      rResp <= next_rResp;
      holdRequest <= next_holdRequest;
      pumpCode <= next_pumpCode;
      irqStatus <= next_irqStatus;
      irqMask <= next_irqMask;
      for (int b = 0; b < NB; b++) begin
        bankSel[b] <= next_bankSel[b];
        bankSleep[b] <= next_bankSleep[b];
      end
      for (int o = 0; o < NO; o++) begin
        outCfg[o] <= next_outCfg[o];
      end
    end
  end

  assign s_axi_bvalid = bValid;
  assign s_axi_bresp = bResp;
  assign s_axi_rvalid = rValid;
  assign s_axi_rdata = rData;
  assign s_axi_rresp = rResp;

  // ****************************************
  // holdover and outputs
  // ****************************************
  // holdover is a live OR, so it ends by itself once input returns and the request is clear
  assign holdoverActive = inputAbsent | holdRequest;
  assign pllTracking = ~holdoverActive;
  assign tuneMidSupply = holdoverActive;
  assign signal_loss_status = inputAbsent;
  assign pump_current_code = pumpCode;
  assign irq = |(irqStatus & irqMask);

  always_comb begin
    for (int b = 0; b < NB; b++) begin
      bankPowered[b] = ~bankSleep[b];
    end
    for (int o = 0; o < NO; o++) begin
      format_select[o] = outCfg[o][csioc_pkg::OUT_FMT_BIT];
      outputAmplitude[2*o +: 2] = outCfg[o][csioc_pkg::OUT_AMP_LSB +: 2];
      // gated low; the bank clock comes from a flop, so this stays glitch-safe per bank
      device_clock_output[o] = bankClock[OUT_BANK[o]] & outCfg[o][csioc_pkg::OUT_GATE_BIT];
    end
  end
endmodule // csioc_top
`default_nettype wire
